// *** rtl/birq_regs.sv ***
// Board interrupt routing, hot-swap and front LED register bank
//
// Notes on behaviour
// R1: Watchdog failure raises NMI or line 5.
// R2: Route field: 11 NMI, 01 line5, 00 off.
// R3: Bit 6 passes power-fail to NMI.
// R4: Bit 5 passes power-fail to line 5.
// R5: Bit 4 passes enumeration to line 5.
// R6: Bit 3 passes derate to line 5.
// R7: Hot-swap bit 6 reads handle open.
// R8: Hot-swap bit 5 drives indicator LED.
// R9: Eight LED bits drive front lamps.
// R10: Power supply drives the power-fail input.
// R11: Everything resets to zero, reserved reads zero.
`timescale 1ns/100ps
module birq_regs
  import birq_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register port
  input wire logic [birq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [birq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [birq_pkg::DATA_W-1:0] reg_rdata,
  // Board signals from pins, asynchronous
  input wire logic watchdog_fail,
  input wire logic backplane_powerfail,
  input wire logic backplane_enum,
  input wire logic backplane_derate,
  input wire logic ejector_handle_open,
  // Routed hardware events
  output logic nmi_out,
  output logic irq5_out,
  // Lamps
  output logic hotswap_indicator_on,
  output logic [birq_pkg::DATA_W-1:0] front_lamp,
  // Sticky event interrupt
  output logic event_irq
);
  import birq_pkg::*;

  birq_bus_req_t req;
  birq_board_in_t pins_raw;
  birq_board_in_t pins;
  logic [NUM_EVENTS-1:0] pins_sync;
  logic [NUM_EVENTS-1:0] pins_prev_reg;
  logic [NUM_EVENTS-1:0] rise;

  birq_wd_route_t watchdog_route_sel;
  logic powerfail_to_nmi_en;
  logic powerfail_to_line5_en;
  logic enumeration_to_line5_en;
  logic derate_to_line5_en;
  logic hs_led_reg;
  logic [DATA_W-1:0] led_reg;
  logic [NUM_EVENTS-1:0] status_reg;
  logic [NUM_EVENTS-1:0] status_next;
  logic [NUM_EVENTS-1:0] enable_reg;
  logic [DATA_W-1:0] rd_next;
  logic nmi_next;
  logic line5_next;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  assign pins_raw = '{watchdog_fail: watchdog_fail,
                      powerfail: backplane_powerfail, // R10
                      enumeration: backplane_enum,
                      derate: backplane_derate,
                      handle_open: ejector_handle_open};

  // Pins are outside the clock domain
  birq_sync #(
    .WIDTH(NUM_EVENTS)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign pins = pins_sync;

  // Routing configuration register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      watchdog_route_sel <= BIRQ_WD_OFF; // R11
      powerfail_to_nmi_en <= 1'b0; // R11
      powerfail_to_line5_en <= 1'b0;
      enumeration_to_line5_en <= 1'b0;
      derate_to_line5_en <= 1'b0;
    end else if (req.wr && req.addr == ROUTING_ADDR) begin
      watchdog_route_sel <=
        birq_wd_route_t'(req.wdata[WD_ROUTE_LSB +: 2]); // R2
      powerfail_to_nmi_en <= req.wdata[PFAIL_NMI_BIT]; // R3
      powerfail_to_line5_en <= req.wdata[PFAIL_LINE5_BIT]; // R4
      enumeration_to_line5_en <= req.wdata[ENUM_LINE5_BIT]; // R5
      derate_to_line5_en <= req.wdata[DERATE_LINE5_BIT]; // R6
    end
  end

  // Hot-swap indicator
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hs_led_reg <= 1'b0; // R11
    end else if (req.wr && req.addr == HOTSWAP_ADDR) begin
      hs_led_reg <= req.wdata[HS_LED_BIT]; // R8
    end
  end

  // Front panel lamps
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      led_reg <= RESET_VALUE; // R11
    end else if (req.wr && req.addr == LED_ADDR) begin
      led_reg <= req.wdata; // R9
    end
  end

  // Event routing; reserved route code routes nowhere
  always_comb begin
    nmi_next = 1'b0;
    line5_next = 1'b0;
    unique case (watchdog_route_sel)
      BIRQ_WD_NMI: nmi_next = pins.watchdog_fail; // R1 R2
      BIRQ_WD_LINE5: line5_next = pins.watchdog_fail; // R1 R2
      BIRQ_WD_OFF: nmi_next = 1'b0; // R2
      BIRQ_WD_RSVD: nmi_next = 1'b0;
    endcase
    if (powerfail_to_nmi_en && pins.powerfail) begin
      nmi_next = 1'b1; // R3
    end
    if (powerfail_to_line5_en && pins.powerfail) begin
      line5_next = 1'b1; // R4
    end
    if (enumeration_to_line5_en && pins.enumeration) begin
      line5_next = 1'b1; // R5
    end
    if (derate_to_line5_en && pins.derate) begin
      line5_next = 1'b1; // R6
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nmi_out <= 1'b0;
      irq5_out <= 1'b0;
    end else begin
      nmi_out <= nmi_next;
      irq5_out <= line5_next;
    end
  end

  assign hotswap_indicator_on = hs_led_reg; // R8
  assign front_lamp = led_reg; // R9

  // Rising edges of the synchronised board signals set sticky bits
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pins_prev_reg <= '0;
    end else begin
      pins_prev_reg <= pins_sync;
    end
  end

  assign rise = pins_sync & ~pins_prev_reg;

  // Set wins over a clear in the same cycle
  always_comb begin
    status_next = status_reg;
    if (req.wr && req.addr == IRQ_CLEAR_ADDR) begin
      status_next = status_next & ~req.wdata[NUM_EVENTS-1:0];
    end
    status_next = status_next | rise;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enable_reg <= '0;
    end else if (req.wr && req.addr == IRQ_ENABLE_ADDR) begin
      enable_reg <= req.wdata[NUM_EVENTS-1:0];
    end
  end

  assign event_irq = |(status_reg & enable_reg);

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    rd_next = UNMAPPED_VALUE;
    unique case (req.addr)
      ROUTING_ADDR: begin
        rd_next[WD_ROUTE_LSB +: 2] = watchdog_route_sel;
        rd_next[PFAIL_NMI_BIT] = powerfail_to_nmi_en;
        rd_next[PFAIL_LINE5_BIT] = powerfail_to_line5_en;
        rd_next[ENUM_LINE5_BIT] = enumeration_to_line5_en;
        rd_next[DERATE_LINE5_BIT] = derate_to_line5_en;
      end
      HOTSWAP_ADDR: begin
        rd_next[HANDLE_OPEN_BIT] = pins.handle_open; // R7
        rd_next[HS_LED_BIT] = hs_led_reg; // R8
      end
      LED_ADDR: rd_next = led_reg; // R9
      IRQ_STATUS_ADDR: rd_next[NUM_EVENTS-1:0] = status_reg;
      IRQ_ENABLE_ADDR: rd_next[NUM_EVENTS-1:0] = enable_reg;
      default: rd_next = UNMAPPED_VALUE; // R11
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (req.rd) begin
      reg_rdata <= rd_next;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : birq_regs

// *** rtl/birq_pkg.sv ***
// Package: register map, field positions and carrier types for the board bank
package birq_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ROUTING_ADDR = 10'h289;
  localparam logic [ADDR_W-1:0] HOTSWAP_ADDR = 10'h28A;
  localparam logic [ADDR_W-1:0] LED_ADDR = 10'h28D;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 10'h290;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = 10'h291;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 10'h292;
  localparam int WD_ROUTE_LSB = 0;
  localparam int DERATE_LINE5_BIT = 3;
  localparam int ENUM_LINE5_BIT = 4;
  localparam int PFAIL_LINE5_BIT = 5;
  localparam int PFAIL_NMI_BIT = 6;
  localparam int HANDLE_OPEN_BIT = 6;
  localparam int HS_LED_BIT = 5;
  localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_VALUE = 8'h00;
  localparam int NUM_EVENTS = 5;
  localparam int EV_WATCHDOG = 0;
  localparam int EV_PFAIL = 1;
  localparam int EV_ENUM = 2;
  localparam int EV_DERATE = 3;
  localparam int EV_HANDLE = 4;

  typedef enum logic [1:0] {
    BIRQ_WD_OFF = 2'h0,
    BIRQ_WD_LINE5 = 2'h1,
    BIRQ_WD_RSVD = 2'h2,
    BIRQ_WD_NMI = 2'h3
  } birq_wd_route_t;

  typedef struct packed {
    logic watchdog_fail;
    logic powerfail;
    logic enumeration;
    logic derate;
    logic handle_open;
  } birq_board_in_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } birq_bus_req_t;
endpackage : birq_pkg

// *** rtl/birq_sync.sv ***
// Two-flip-flop synchroniser for a vector of board level inputs
`timescale 1ns/100ps
module birq_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule : birq_sync

// *** tb/birq_props.sv ***
// Checker for the board routing register bank
`timescale 1ns/100ps
module birq_props
  import birq_pkg::*;
(
  input wire logic ref_clk, srst, reg_wr, reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata, reg_rdata, front_lamp,
  input wire logic watchdog_fail, backplane_powerfail, backplane_enum,
  input wire logic backplane_derate, ejector_handle_open,
  input wire logic nmi_out, irq5_out, hotswap_indicator_on
);
  logic [4:0] s1, s2;
  logic [7:0] cfg;
  logic en_nmi, en_i5;
  // Shadow of the pin synchroniser and routing register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      {s1, s2, cfg, en_nmi, en_i5} <= '0;
    end else begin
      s1 <= {watchdog_fail, backplane_powerfail, backplane_enum,
        backplane_derate, ejector_handle_open};
      s2 <= s1;
      if (reg_wr && reg_addr == ROUTING_ADDR) cfg <= reg_wdata & 8'h7B;
      en_nmi <= (cfg[1:0] == 2'h3 && s2[4]) || (cfg[6] && s2[3]);
      en_i5 <= (cfg[1:0] == 2'h1 && s2[4]) || (cfg[5] && s2[3]) ||
        (cfg[4] && s2[2]) || (cfg[3] && s2[1]);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_nmi; nmi_out == en_nmi; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi wrong");
  property p_irq5; irq5_out == en_i5; endproperty
  a_irq5: assert property (p_irq5) else $error("irq5 wrong");
  property p_lamp_wr; reg_wr && reg_addr == LED_ADDR |=>
    front_lamp == $past(reg_wdata); endproperty
  a_lamp_wr: assert property (p_lamp_wr) else $error("lamp wr");
  property p_lamp_hold; !(reg_wr && reg_addr == LED_ADDR) |=>
    $stable(front_lamp); endproperty
  a_lamp_hold: assert property (p_lamp_hold) else $error("lamp");
  property p_hs_wr; reg_wr && reg_addr == HOTSWAP_ADDR |=>
    hotswap_indicator_on == $past(reg_wdata[5]); endproperty
  a_hs_wr: assert property (p_hs_wr) else $error("hs led");
  property p_hs_rd; reg_rd && reg_addr == HOTSWAP_ADDR |=> reg_rdata ==
    {1'b0, $past(s2[0]), $past(hotswap_indicator_on), 5'h00}; endproperty
  a_hs_rd: assert property (p_hs_rd) else $error("hs read");
  property p_cfg_rd; reg_rd && reg_addr == ROUTING_ADDR |=>
    reg_rdata == $past(cfg); endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("cfg read");
  property p_lamp_rd; reg_rd && reg_addr == LED_ADDR |=>
    reg_rdata == $past(front_lamp); endproperty
  a_lamp_rd: assert property (p_lamp_rd) else $error("lamp rd");
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata idle");
endmodule : birq_props
bind birq_regs birq_props u_props (.*);

// *** tb/birq_board_model.sv ***
// Board-side model: backplane and ejector levels
`timescale 1ns/100ps
module birq_board_model
  import birq_pkg::*;
(
  input wire birq_pkg::birq_board_in_t cmd,
  output logic watchdog_fail, backplane_powerfail, backplane_enum,
  output logic backplane_derate, ejector_handle_open
);
  assign watchdog_fail = cmd.watchdog_fail;
  assign backplane_powerfail = cmd.powerfail;
  assign backplane_enum = cmd.enumeration;
  assign backplane_derate = cmd.derate;
  assign ejector_handle_open = cmd.handle_open;
endmodule : birq_board_model

// *** tb/tb_birq_regs.sv ***
// Testbench for the board routing register bank
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_birq_regs;
  import birq_pkg::*;
  logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, front_lamp;
  logic nmi_out, irq5_out, hotswap_indicator_on, event_irq, wd, pf, en, dr, ho;
  birq_board_in_t cmd = '0;
  int error_cnt = 0, comparisons = 0;
  logic [7:0] cfg_t [9] = '{8'h03, 8'h01, 8'h00, 8'h03, 8'h40, 8'h38,
    8'h10, 8'h08, 8'h70};
  logic [4:0] pin_t [9] = '{5'h10, 5'h10, 5'h10, 5'h08, 5'h08, 5'h08,
    5'h04, 5'h02, 5'h02};
  logic [1:0] out_t [9] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1,
    2'h1, 2'h0};
  always #20 ref_clk = ~ref_clk;
  birq_board_model board (.cmd(cmd), .watchdog_fail(wd),
    .backplane_powerfail(pf), .backplane_enum(en), .backplane_derate(dr),
    .ejector_handle_open(ho));
  birq_regs dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .watchdog_fail(wd), .backplane_powerfail(pf),
    .backplane_enum(en), .backplane_derate(dr), .ejector_handle_open(ho),
    .nmi_out(nmi_out), .irq5_out(irq5_out), .front_lamp(front_lamp),
    .hotswap_indicator_on(hotswap_indicator_on), .event_irq(event_irq));
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rc
  task automatic conclude();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rc(ROUTING_ADDR, 8'h00);
    rc(HOTSWAP_ADDR, 8'h00);
    rc(LED_ADDR, 8'h00);
    `CHK({nmi_out, irq5_out, hotswap_indicator_on, front_lamp}, 11'h0)
    $display("test reset done");
    wr(LED_ADDR, 8'hA5);
    wr(10'h28B, 8'hFF);
    rc(10'h28B, 8'h00);
    rc(LED_ADDR, 8'hA5);
    wr(LED_ADDR, 8'h5A);
    #1 `CHK(front_lamp, 8'h5A)
    $display("test lamps done");
    wr(HOTSWAP_ADDR, 8'hFF);
    #1 `CHK(hotswap_indicator_on, 1'b1)
    rc(HOTSWAP_ADDR, 8'h20);
    wr(HOTSWAP_ADDR, 8'h00);
    #1 `CHK(hotswap_indicator_on, 1'b0)
    wr(HOTSWAP_ADDR, 8'h20);
    @(posedge ref_clk);
    cmd.handle_open <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rc(HOTSWAP_ADDR, 8'h60);
    $display("test hot swap done");
    for (int i = 0; i < 9; i++) begin
      wr(ROUTING_ADDR, cfg_t[i]);
      cmd <= birq_board_in_t'(pin_t[i]);
      repeat (4) @(posedge ref_clk);
      #1 `CHK({nmi_out, irq5_out}, out_t[i])
      rc(ROUTING_ADDR, cfg_t[i]);
    end
    $display("test routing done");
    cmd <= '0;
    wr(ROUTING_ADDR, 8'hFF);
    rc(ROUTING_ADDR, 8'h7B);
    wr(IRQ_ENABLE_ADDR, 8'h02);
    #1 `CHK(event_irq, 1'b1)
    rc(IRQ_STATUS_ADDR, 8'h1F);
    wr(IRQ_ENABLE_ADDR, 8'h00);
    #1 `CHK(event_irq, 1'b0)
    wr(IRQ_CLEAR_ADDR, 8'h1F);
    rc(IRQ_STATUS_ADDR, 8'h00);
    $display("test events done");
    conclude();
  end
endmodule : tb_birq_regs
